// ### verilog/epm_pkg.sv
// package: widths, idle pin levels and owner states of the external bus pin mux
package epm_pkg;
   // ****************************************
   // bus widths
   // ****************************************
   localparam int ADDR_W = 23; // external address pins
   localparam int DATA_W = 32; // full data bus
   localparam int HALF_W = 16; // static data width
   localparam int CS_W = 8; // chip-select lines
   localparam int SD_ADDR_W = 13; // sdram controller address
   localparam int MASK_W = 4; // sdram byte masks

   // ****************************************
   // idle and reset levels
   // ****************************************
   localparam logic [CS_W-1:0] CS_IDLE = 8'hFF; // no chip selected
   localparam logic STROBE_OFF = 1'h1; // active-low strobe released
   localparam logic [ADDR_W-1:0] ADDR_IDLE = 23'h000000; // address parked
   localparam logic [DATA_W-1:0] DATA_IDLE = 32'h00000000; // data parked
   localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000; // unused upper half

   // ****************************************
   // pin ownership states, one-hot
   // ****************************************
   typedef enum logic [2:0] {
      OWN_IDLE = 3'h1,
      OWN_STATIC = 3'h2,
      OWN_SDRAM = 3'h4
   } epm_own_state_t;
endpackage

// ### verilog/epm_own_if.sv
// interface: access requests and pin grants between the mux and its owner arbiter
interface epm_own_if;
   logic staticReq; // static controller holds an access
   logic sdramReq; // sdram controller holds an access
   logic staticGrant; // static controller owns the pins
   logic sdramGrant; // sdram controller owns the pins
   modport arb (input staticReq, input sdramReq, output staticGrant, output sdramGrant);
   modport user (output staticReq, output sdramReq, input staticGrant, input sdramGrant);
endinterface

// ### verilog/epm_owner_arb.sv
// module: decides which memory controller owns the shared external pins
module epm_owner_arb (
   input wire logic core_clk,
   input wire logic rstn,
   epm_own_if.arb own
);
   epm_pkg::epm_own_state_t state; // current owner
   epm_pkg::epm_own_state_t next_state; // owner for next cycle

   // ownership passes through idle, so a new owner never cuts into an access
   always_comb begin
      next_state = state;
      case (state)
         epm_pkg::OWN_IDLE: begin
            // sdram first: refresh cannot wait behind a slow static device
            if (own.sdramReq) begin
               next_state = epm_pkg::OWN_SDRAM;
            end else if (own.staticReq) begin
               next_state = epm_pkg::OWN_STATIC;
            end
         end
         epm_pkg::OWN_STATIC: begin
            // release only when the whole access is done
            if (!own.staticReq) begin
               next_state = epm_pkg::OWN_IDLE;
            end
         end
         epm_pkg::OWN_SDRAM: begin
            if (!own.sdramReq) begin
               next_state = epm_pkg::OWN_IDLE;
            end
         end
         default: begin
            next_state = epm_pkg::OWN_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state <= epm_pkg::OWN_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // grants decode straight from the one-hot state bits
   assign own.staticGrant = state[1];
   assign own.sdramGrant = state[2];
endmodule

// ### verilog/epm_pin_mux.sv
// module: shares external bus pins between the static and sdram controllers
// Notes on behaviour
// R01 - 16/32-bit data, 23 address, eight selects
// R02 - eight devices, each own active-low select
// R03 - owning controller drives each shared pin
// R04 - sdram address remapped; upper data sdram only
// R05 - sdram select on second chip-select pin
// R06 - sdram row, column, write strobes active-low
// R07 - sdram address bit ten on own pin
// R08 - nand command latch on address pin 22
// R09 - nand address latch on address pin 21
// R10 - dedicated active-low nand read, write strobes
// R11 - nand select on fourth chip-select pin
// R12 - card direction on first select, high read
// R13 - card io read on upper-byte strobe pin
// R14 - card io write on byte mask three
// R15 - two card selects on static select pins
// R16 - single owner, swaps between accesses, idle quiet
// R17 - external wait stretches static or card access
module epm_pin_mux (
   input wire logic core_clk,
   input wire logic rstn,
   // ****************************************
   // static controller side
   // ****************************************
   input wire logic staticReq,
   input wire logic [22:0] staticAddr,
   input wire logic [7:0] staticSelN,
   input wire logic staticReadN,
   input wire logic [1:0] byteWriteStrobeN,
   input wire logic [15:0] staticDataOut,
   input wire logic staticDataOe,
   input wire logic nandMode,
   input wire logic nandCmdLatchN,
   input wire logic nandAddrLatchN,
   input wire logic nandReadInN,
   input wire logic nandWriteInN,
   input wire logic cardMode,
   input wire logic cardDir,
   input wire logic cardIoReadInN,
   input wire logic cardIoWriteInN,
   output logic staticGrant,
   output logic staticWaitN,
   // ****************************************
   // sdram controller side
   // ****************************************
   input wire logic sdramReq,
   input wire logic [12:0] sdramAddr,
   input wire logic [1:0] sdramBank,
   input wire logic sdramSelN,
   input wire logic sdramRasN,
   input wire logic sdramCasN,
   input wire logic sdramWriteInN,
   input wire logic sdramClkEnIn,
   input wire logic [3:0] byteMaskN,
   input wire logic [31:0] sdramDataOut,
   input wire logic sdramDataOe,
   input wire logic busWide32,
   output logic sdramGrant,
   output logic [31:0] readData,
   // ****************************************
   // external pins
   // ****************************************
   output logic [22:0] addrPin,
   output logic [7:0] chipSelectN,
   output logic readStrobeN,
   output logic writeStrobeN,
   output logic upperStrobeN,
   output logic byteMask3N,
   output logic nandReadN,
   output logic nandWriteN,
   output logic rasN,
   output logic casN,
   output logic sdramWriteN,
   output logic sdramClkEn,
   output logic sdramAddrBit10,
   input wire logic [31:0] dataIn,
   output logic [31:0] dataOut,
   output logic dataOeLo,
   output logic dataOeHi,
   input wire logic extWaitN
);
   // ****************************************
   // ownership
   // ****************************************
   epm_own_if own (); // request and grant bundle
   logic isStatic; // static controller owns pins this cycle
   logic isSdram; // sdram controller owns pins this cycle
   logic isNand; // static owner in nand mode
   logic isCard; // static owner in card mode

   assign own.staticReq = staticReq;
   assign own.sdramReq = sdramReq;

   epm_owner_arb u_arb (
      .core_clk(core_clk),
      .rstn(rstn),
      .own(own)
   );

   assign isStatic = own.staticGrant; // [R16]
   assign isSdram = own.sdramGrant; // [R16]
   assign isNand = isStatic && nandMode;
   assign isCard = isStatic && cardMode;

   // ****************************************
   // next pin values, selected by owner
   // ****************************************
   logic [22:0] next_addrPin;
   logic [22:0] staticAddrMux; // static address with nand latches
   logic [22:0] sdramAddrMux; // sdram address as it lies on the pins
   logic [7:0] next_chipSelectN;
   logic [7:0] staticSelMux; // static selects with card direction
   logic next_upperStrobeN;
   logic next_byteMask3N;
   logic [31:0] next_dataOut;

   // nand latches replace the two top address bits
   assign staticAddrMux = {isNand ? nandCmdLatchN : staticAddr[22], // [R08]
                           isNand ? nandAddrLatchN : staticAddr[21], // [R09]
                           staticAddr[20:0]};
   // column/row bits 9..0 on 11..2, 12..11 on 14..13, banks on 17..16, masks 2 and 0 low
   assign sdramAddrMux = {5'h00, sdramBank, 1'h0, sdramAddr[12:11], 1'h0,
                          sdramAddr[9:0], byteMaskN[2], byteMaskN[0]}; // [R04]
   assign next_addrPin = isSdram ? sdramAddrMux :
                         isStatic ? staticAddrMux : epm_pkg::ADDR_IDLE; // [R03]

   // first select turns into card direction, high meaning read
   assign staticSelMux = {staticSelN[7:1], isCard ? cardDir : staticSelN[0]}; // [R12]
   // one low select per device; card and nand selects ride on static lines
   assign next_chipSelectN = isSdram ? {6'h3F, sdramSelN, 1'h1} : // [R05]
                             isStatic ? staticSelMux : epm_pkg::CS_IDLE; // [R02] [R11] [R15]

   // upper byte write, sdram mask 1, card io read share one pin
   assign next_upperStrobeN = isSdram ? byteMaskN[1] :
                              isCard ? cardIoReadInN : // [R13]
                              isStatic ? byteWriteStrobeN[1] : epm_pkg::STROBE_OFF;
   // sdram mask 3 and card io write share one pin
   assign next_byteMask3N = isSdram ? byteMaskN[3] :
                            isCard ? cardIoWriteInN : epm_pkg::STROBE_OFF; // [R14]
   // static device only reaches the lower half of the data bus
   assign next_dataOut = isSdram ? sdramDataOut :
                         isStatic ? {epm_pkg::HALF_ZERO, staticDataOut} :
                         epm_pkg::DATA_IDLE; // [R01] [R04]

   // ****************************************
   // pin registers
   // ****************************************
   // address, selects and shared strobes; all released under reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         addrPin <= epm_pkg::ADDR_IDLE;
         chipSelectN <= epm_pkg::CS_IDLE;
         upperStrobeN <= epm_pkg::STROBE_OFF;
         byteMask3N <= epm_pkg::STROBE_OFF;
         readStrobeN <= epm_pkg::STROBE_OFF;
         writeStrobeN <= epm_pkg::STROBE_OFF;
      end else begin
         addrPin <= next_addrPin;
         chipSelectN <= next_chipSelectN;
         upperStrobeN <= next_upperStrobeN;
         byteMask3N <= next_byteMask3N;
         readStrobeN <= isStatic ? staticReadN : epm_pkg::STROBE_OFF; // [R03]
         writeStrobeN <= isStatic ? byteWriteStrobeN[0] : epm_pkg::STROBE_OFF;
      end
   end

   // dedicated nand and sdram lines; all but clock enable idle when their controller is not owner
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         nandReadN <= epm_pkg::STROBE_OFF;
         nandWriteN <= epm_pkg::STROBE_OFF;
         rasN <= epm_pkg::STROBE_OFF;
         casN <= epm_pkg::STROBE_OFF;
         sdramWriteN <= epm_pkg::STROBE_OFF;
         sdramAddrBit10 <= 1'h0;
         sdramClkEn <= 1'h0;
      end else begin
         nandReadN <= isNand ? nandReadInN : epm_pkg::STROBE_OFF; // [R10]
         nandWriteN <= isNand ? nandWriteInN : epm_pkg::STROBE_OFF; // [R10]
         rasN <= isSdram ? sdramRasN : epm_pkg::STROBE_OFF; // [R06]
         casN <= isSdram ? sdramCasN : epm_pkg::STROBE_OFF; // [R06]
         sdramWriteN <= isSdram ? sdramWriteInN : epm_pkg::STROBE_OFF; // [R06]
         sdramAddrBit10 <= isSdram && sdramAddr[10]; // [R07]
         // clock enable is not shared, so self refresh holds across owners
         sdramClkEn <= sdramClkEnIn;
      end
   end

   // data lanes, grants and returns to the controllers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dataOut <= epm_pkg::DATA_IDLE;
         dataOeLo <= 1'h0;
         dataOeHi <= 1'h0;
         readData <= epm_pkg::DATA_IDLE;
         staticWaitN <= epm_pkg::STROBE_OFF;
         staticGrant <= 1'h0;
         sdramGrant <= 1'h0;
      end else begin
         dataOut <= next_dataOut;
         dataOeLo <= (isSdram && sdramDataOe) || (isStatic && staticDataOe); // [R03]
         dataOeHi <= isSdram && sdramDataOe && busWide32; // [R01] [R04]
         readData <= dataIn;
         // wait only matters to the static side; it stretches its strobes
         staticWaitN <= extWaitN; // [R17]
         staticGrant <= isStatic;
         sdramGrant <= isSdram;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   a_owner_single: assert property (!(isStatic && isSdram)) // [R16]
      else $error("both controllers own the pins");
   a_swap_via_idle: assert property ($rose(isSdram) |-> $past(!isStatic)) // [R16]
      else $error("owner changed without idle gap");
   a_idle_quiet: assert property (!isStatic && !isSdram |=> chipSelectN == 8'hFF && !dataOeLo
      && !dataOeHi && rasN && readStrobeN) // [R16]
      else $error("pins active without owner");
   a_sdram_addr_map: assert property (isSdram |=> addrPin[11:2] == $past(sdramAddr[9:0])
      && addrPin[14:13] == $past(sdramAddr[12:11]) && addrPin[17:16] == $past(sdramBank)) // [R04]
      else $error("sdram address mapped wrongly");
   a_sdram_select: assert property (isSdram && !sdramSelN |=> chipSelectN == 8'hFD) // [R05]
      else $error("sdram select not on second line");
   a_bit10_static: assert property (isStatic |=> !sdramAddrBit10 && rasN && casN) // [R07]
      else $error("sdram lines moved in static access");
   a_nand_latches: assert property (isNand |=> addrPin[22] == $past(nandCmdLatchN)
      && addrPin[21] == $past(nandAddrLatchN)) // [R08]
      else $error("nand latches not on top address pins");
   a_nand_strobes: assert property (!isNand |=> nandReadN && nandWriteN) // [R10]
      else $error("nand strobe active outside nand access");
   a_card_dir: assert property (isCard |=> chipSelectN[0] == $past(cardDir)) // [R12]
      else $error("card direction not on first select");
   a_card_io: assert property (isCard |=> upperStrobeN == $past(cardIoReadInN)
      && byteMask3N == $past(cardIoWriteInN)) // [R13]
      else $error("card io strobes misplaced");
   a_static_upper: assert property (isStatic |=> dataOut[31:16] == 16'h0000 && !dataOeHi) // [R04]
      else $error("static access drove upper data");

   c_sdram_access: cover property (isSdram && !sdramSelN ##1 !chipSelectN[1]);
   c_static_then_sdram: cover property (isStatic ##1 !isStatic ##1 isSdram);
   c_nand_cmd: cover property (isNand && !nandCmdLatchN);
   c_card_read: cover property (isCard && cardDir && !cardIoReadInN);
endmodule

// ### sim/epm_mem_model.sv
// partner model: external memory that answers reads and can stretch an access
module epm_mem_model (
   input wire logic core_clk,
   input wire logic [7:0] chipSelectN,
   input wire logic readStrobeN,
   input wire logic [22:0] addrPin,
   input wire logic slowMode,
   output logic [31:0] dataIn,
   output logic extWaitN
);
   timeunit 1ns;
   timeprecision 1ns;
   logic selected; // some device on the bus is selected
   assign selected = (chipSelectN !== 8'hFF);
   initial begin
      dataIn = 32'h5A5A5A5A;
      extWaitN = 1'h1;
   end
   // ****************************************
   // bus answer
   // ****************************************
   // no pull on the data bus, so a released bus toggles instead of holding stale data
   always @(posedge core_clk) begin
      if (selected && !readStrobeN) begin
         dataIn <= {9'h000, addrPin};
      end else begin
         dataIn <= ~dataIn;
      end
      // slow device holds wait low for as long as it is selected
      extWaitN <= !(slowMode && selected);
   end
endmodule

// ### sim/external_bus_pin_mux_bench.sv
// testbench: scenarios for the external bus pin mux against a memory model
module external_bus_pin_mux_bench;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // signals
   // ****************************************
   logic core_clk, rstn, staticReq, staticReadN, staticDataOe, nandMode, slowMode;
   logic nandCmdLatchN, nandAddrLatchN, nandReadInN, nandWriteInN, cardMode, cardDir;
   logic cardIoReadInN, cardIoWriteInN, sdramReq, sdramSelN, sdramRasN, sdramCasN;
   logic sdramWriteInN, sdramClkEnIn, sdramDataOe, busWide32, extWaitN, staticGrant;
   logic staticWaitN, sdramGrant, readStrobeN, writeStrobeN, upperStrobeN, byteMask3N;
   logic nandReadN, nandWriteN, rasN, casN, sdramWriteN, sdramClkEn, sdramAddrBit10;
   logic dataOeLo, dataOeHi;
   logic [22:0] staticAddr, addrPin;
   logic [7:0] staticSelN, chipSelectN;
   logic [1:0] byteWriteStrobeN, sdramBank;
   logic [15:0] staticDataOut;
   logic [12:0] sdramAddr;
   logic [3:0] byteMaskN;
   logic [31:0] sdramDataOut, readData, dataIn, dataOut;
   int n_errors = 0; // mismatches seen
   int n_checks = 0; // comparisons made
   epm_pin_mux DUT (
      .core_clk(core_clk), .rstn(rstn), .staticReq(staticReq), .staticAddr(staticAddr),
      .staticSelN(staticSelN), .staticReadN(staticReadN), .byteWriteStrobeN(byteWriteStrobeN),
      .staticDataOut(staticDataOut), .staticDataOe(staticDataOe), .nandMode(nandMode),
      .nandCmdLatchN(nandCmdLatchN), .nandAddrLatchN(nandAddrLatchN),
      .nandReadInN(nandReadInN), .nandWriteInN(nandWriteInN), .cardMode(cardMode),
      .cardDir(cardDir), .cardIoReadInN(cardIoReadInN), .cardIoWriteInN(cardIoWriteInN),
      .staticGrant(staticGrant), .staticWaitN(staticWaitN), .sdramReq(sdramReq),
      .sdramAddr(sdramAddr), .sdramBank(sdramBank), .sdramSelN(sdramSelN),
      .sdramRasN(sdramRasN), .sdramCasN(sdramCasN), .sdramWriteInN(sdramWriteInN),
      .sdramClkEnIn(sdramClkEnIn), .byteMaskN(byteMaskN), .sdramDataOut(sdramDataOut),
      .sdramDataOe(sdramDataOe), .busWide32(busWide32), .sdramGrant(sdramGrant),
      .readData(readData), .addrPin(addrPin), .chipSelectN(chipSelectN),
      .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .upperStrobeN(upperStrobeN),
      .byteMask3N(byteMask3N), .nandReadN(nandReadN), .nandWriteN(nandWriteN),
      .rasN(rasN), .casN(casN), .sdramWriteN(sdramWriteN), .sdramClkEn(sdramClkEn),
      .sdramAddrBit10(sdramAddrBit10), .dataIn(dataIn), .dataOut(dataOut),
      .dataOeLo(dataOeLo), .dataOeHi(dataOeHi), .extWaitN(extWaitN)
   );
   epm_mem_model partner (
      .core_clk(core_clk), .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
      .addrPin(addrPin), .slowMode(slowMode), .dataIn(dataIn), .extWaitN(extWaitN)
   );
   // clock at 25 MHz
   initial core_clk = 1'h0;
   always #20 core_clk = ~core_clk;
   // ****************************************
   // helpers
   // ****************************************
   // wide enough for the longest bundle of pins compared in one go
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // wait edges, then look once the edge updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // every request off and every strobe released
   task automatic park();
      {staticReq, sdramReq, nandMode, cardMode, cardDir, slowMode} <= 6'h00;
      {staticReadN, nandCmdLatchN, nandAddrLatchN, nandReadInN, nandWriteInN} <= 5'h1F;
      {cardIoReadInN, cardIoWriteInN, sdramSelN, sdramRasN, sdramCasN} <= 5'h1F;
      {sdramWriteInN, sdramClkEnIn, sdramDataOe, busWide32, staticDataOe} <= 5'h18;
      byteWriteStrobeN <= 2'h3;
      staticSelN <= 8'hFF;
      staticAddr <= 23'h000000;
      staticDataOut <= 16'h0000;
      sdramAddr <= 13'h0000;
      sdramBank <= 2'h0;
      byteMaskN <= 4'hF;
      sdramDataOut <= 32'h00000000;
   endtask
   task automatic close_out();
      if (n_errors == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   // nand access through the static side, read data returned one cycle late
   task automatic test_nand();
      @(posedge core_clk);
      {staticReq, nandMode, staticDataOe, nandAddrLatchN} <= 4'hF;
      {nandCmdLatchN, nandReadInN, staticReadN} <= 3'h0;
      staticSelN <= 8'hF7;
      staticAddr <= 23'h1ABCDE;
      staticDataOut <= 16'hBEEF;
      tick(3);
      chk("staticGrant", 1, staticGrant);
      chk("addrPin", {2'h1, 21'h1ABCDE}, addrPin);
      chk("chipSelectN", 8'hF7, chipSelectN);
      chk("nand strobes", 2'h1, {nandReadN, nandWriteN});
      chk("read strobes", 2'h1, {readStrobeN, writeStrobeN});
      chk("sdram lines", 3'h7, {rasN, casN, sdramWriteN});
      chk("data drive", {1'h1, 1'h0, 32'h0000BEEF}, {dataOeLo, dataOeHi, dataOut});
      tick(2);
      chk("readData", {9'h000, 2'h1, 21'h1ABCDE}, readData);
      @(posedge core_clk);
      staticReq <= 1'h0;
      tick(3);
      chk("idle pins", {2'h0, 8'hFF, 23'h0}, {staticGrant, sdramGrant, chipSelectN, addrPin});
      @(posedge core_clk);
      park();
   endtask
   // card access with direction, io strobes and a stretched wait
   task automatic test_card();
      @(posedge core_clk);
      {staticReq, cardMode, cardDir, slowMode, cardIoWriteInN} <= 5'h1F;
      cardIoReadInN <= 1'h0;
      staticSelN <= 8'hEB;
      tick(3);
      chk("card selects", 8'hEB, chipSelectN);
      chk("card io", 2'h1, {upperStrobeN, byteMask3N});
      @(posedge core_clk);
      {cardDir, cardIoWriteInN} <= 2'h0;
      cardIoReadInN <= 1'h1;
      tick(1);
      chk("card write", {8'hEA, 2'h2}, {chipSelectN, upperStrobeN, byteMask3N});
      chk("staticWaitN", 0, staticWaitN);
      chk("staticGrant held", 1, staticGrant);
      @(posedge core_clk);
      slowMode <= 1'h0;
      staticReq <= 1'h0;
      tick(3);
      chk("wait released", {1'h1, 8'hFF}, {staticWaitN, chipSelectN});
      @(posedge core_clk);
      park();
   endtask
   // both ask at once: sdram wins, static waits for the idle cycle
   task automatic test_sdram();
      int n;
      @(posedge core_clk);
      {sdramReq, staticReq, sdramClkEnIn, sdramDataOe, busWide32, sdramCasN} <= 6'h3F;
      {sdramSelN, sdramRasN, sdramWriteInN} <= 3'h0;
      staticSelN <= 8'hFE;
      // static write strobes wait underneath the sdram access and show once static owns
      byteWriteStrobeN <= 2'h0;
      sdramAddr <= 13'h1555;
      sdramBank <= 2'h2;
      byteMaskN <= 4'hA;
      sdramDataOut <= 32'hCAFE1234;
      tick(3);
      chk("grants", 2'h1, {staticGrant, sdramGrant});
      chk("sdram addr", {5'h00, 2'h2, 1'h0, 2'h2, 1'h0, 10'h155, 1'h0, 1'h0}, addrPin);
      chk("sdramAddrBit10", 1, sdramAddrBit10);
      chk("chipSelectN", 8'hFD, chipSelectN);
      chk("ras cas we", 3'h2, {rasN, casN, sdramWriteN});
      chk("masks", 3'h7, {upperStrobeN, byteMask3N, readStrobeN});
      chk("wide data", {2'h3, 32'hCAFE1234}, {dataOeLo, dataOeHi, dataOut});
      chk("sdramClkEn", 1, sdramClkEn);
      @(posedge core_clk);
      busWide32 <= 1'h0;
      tick(1);
      chk("narrow data", 2'h2, {dataOeLo, dataOeHi});
      @(posedge core_clk);
      sdramReq <= 1'h0;
      // owner idles one edge later, pins and grants follow at the next
      tick(2);
      chk("idle between owners", {2'h0, 8'hFF}, {staticGrant, sdramGrant, chipSelectN});
      n = 0;
      while (staticGrant !== 1'h1 && n < 6) begin
         tick(1);
         n++;
      end
      chk("static after sdram", {2'h2, 8'hFE}, {staticGrant, sdramGrant, chipSelectN});
      chk("static writes", 2'h0, {writeStrobeN, upperStrobeN});
      @(posedge core_clk);
      staticReq <= 1'h0;
      tick(3);
      @(posedge core_clk);
      park();
   endtask
   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      rstn = 1'h0;
      park();
      tick(2);
      chk("reset pins", {8'hFF, 23'h0, 2'h3, 2'h0}, {chipSelectN, addrPin, readStrobeN,
         writeStrobeN, dataOeLo, dataOeHi});
      chk("reset flags", {2'h0, 3'h4, 32'h0}, {staticGrant, sdramGrant, staticWaitN,
         sdramClkEn, sdramAddrBit10, readData});
      @(posedge core_clk);
      rstn <= 1'h1;
      test_nand();
      test_card();
      test_sdram();
      close_out();
   end
   // a hung handshake ends the run as a failure
   initial begin
      repeat (2000) @(posedge core_clk);
      n_errors++;
      close_out();
   end
endmodule
